// file: hw/esh_bank.sv
/*
 * Error SCI enable register, scratch storage and host error status
 * flags, reached over a classic Wishbone slave. Raises one-cycle SCI
 * message requests toward the downstream hub link.
 * Assumes event inputs are synchronous one-cycle pulses from core logic,
 * and the two host error signals are active-low pins from outside.
 */
`timescale 1ns/1ps
`include "esh_regs.svh"

// Function
// - Enable bit 4 sends SCI for AGP access outside aperture
// - Enable bit 3 sends SCI for invalid AGP low-region or above-memory access
// - Enable bit 2 sends SCI for invalid translation table entry
// - Enable bit 1 sends SCI on multi-bit ECC; keep clear without ECC
// - Enable bit 0 sends SCI on single-bit ECC; keep clear without ECC
// - Sixteen-bit scratch storage, plain read/write, no other effect
// - Host error register at offset e0, two bytes, resets to zero
// - Bit 15 sets on bus error signal, cleared by writing one
// - Bit 14 sets on internal error signal, cleared by writing one
module esh_bank
    import esh_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        out_of_aperture_i,
    input  wire logic        invalid_gfx_access_i,
    input  wire logic        bad_translation_entry_i,
    input  wire logic        multibit_mem_error_i,
    input  wire logic        singlebit_mem_error_i,
    input  wire logic        host_bus_error_signal_n_i,
    input  wire logic        host_internal_error_signal_n_i,
    output logic             sci_msg_o,
    output logic [4:0]       sci_cause_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    esh_word_t                  sci_en_r;
    esh_word_t                  scratch_r;
    esh_word_t                  herr_r;
    logic [`ESH_NUM_IRQ-1:0]    irq_stat_r;
    logic [`ESH_NUM_IRQ-1:0]    irq_mask_r;
    esh_bus_st_t                bus_st_r;
    logic [31:0]                rdat_r;
    logic                       err_r;
    logic [1:0]                 host_bus_error_signal_sync_r;
    logic [1:0]                 host_internal_error_signal_sync_r;
    logic                       host_bus_error_signal_prev_r;
    logic                       host_internal_error_signal_prev_r;
    logic                       sci_msg_r;
    logic [4:0]                 sci_cause_r;

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire        req        = wb_cyc_i & wb_stb_i & (bus_st_r == ESH_IDLE);
    wire        wr         = req & wb_we_i;
    wire        rd         = req & ~wb_we_i;
    wire        hit_sci    = (wb_adr_i == `ESH_OFF_SCI_EN);
    wire        hit_scr    = (wb_adr_i == `ESH_OFF_SCRATCH);
    wire        hit_herr   = (wb_adr_i == `ESH_OFF_HERR);
    wire        hit_ist    = (wb_adr_i == `ESH_OFF_IRQ_STAT);
    wire        hit_imk    = (wb_adr_i == `ESH_OFF_IRQ_MASK);
    wire        hit_any    = hit_sci | hit_scr | hit_herr | hit_ist | hit_imk;
    wire [15:0] lane_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] wdat       = wb_dat_i[15:0];

    ////////////////////////////////////////////////////////////////////
    // Host error pin synchronisers and edge detect
    wire        host_bus_error_signal_lvl   = ~host_bus_error_signal_sync_r[1];
    wire        host_internal_error_signal_lvl   = ~host_internal_error_signal_sync_r[1];
    wire        host_bus_error_signal_ev    = host_bus_error_signal_lvl & ~host_bus_error_signal_prev_r;
    wire        host_internal_error_signal_ev    = host_internal_error_signal_lvl & ~host_internal_error_signal_prev_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_bus_error_signal_sync_r <= 2'h3;
            host_internal_error_signal_sync_r <= 2'h3;
            host_bus_error_signal_prev_r <= 1'b0;
            host_internal_error_signal_prev_r <= 1'b0;
        end else begin
            host_bus_error_signal_sync_r <= {host_bus_error_signal_sync_r[0], host_bus_error_signal_n_i};
            host_internal_error_signal_sync_r <= {host_internal_error_signal_sync_r[0], host_internal_error_signal_n_i};
            host_bus_error_signal_prev_r <= host_bus_error_signal_lvl;
            host_internal_error_signal_prev_r <= host_internal_error_signal_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // SCI enable and scratch storage
    wire [15:0] sci_en_nxt = (wr && hit_sci) ?
        (((sci_en_r & ~lane_mask) | (wdat & lane_mask)) & `ESH_SCI_EN_MASK) : sci_en_r;
    wire [15:0] scratch_nxt = (wr && hit_scr) ?
        ((scratch_r & ~lane_mask) | (wdat & lane_mask)) : scratch_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sci_en_r  <= `ESH_SCI_EN_RST;
            scratch_r <= `ESH_SCRATCH_RST;
        end else begin
            sci_en_r  <= sci_en_nxt;
            scratch_r <= scratch_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Host error status, write one to clear, set wins
    wire        herr_wr    = wr & hit_herr & wb_sel_i[1];
    wire        host_bus_error_signal_clr   = herr_wr & wdat[`ESH_HERR_HOST_BUS_ERROR_SIGNAL];
    wire        host_internal_error_signal_clr   = herr_wr & wdat[`ESH_HERR_HOST_INTERNAL_ERROR_SIGNAL];
    wire        host_bus_error_signal_nxt   = host_bus_error_signal_ev | (herr_r[`ESH_HERR_HOST_BUS_ERROR_SIGNAL] & ~host_bus_error_signal_clr);
    wire        host_internal_error_signal_nxt   = host_internal_error_signal_ev | (herr_r[`ESH_HERR_HOST_INTERNAL_ERROR_SIGNAL] & ~host_internal_error_signal_clr);
    wire [15:0] herr_nxt   = {host_bus_error_signal_nxt, host_internal_error_signal_nxt, 14'h0000};

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            herr_r <= `ESH_HERR_RST;
        end else begin
            herr_r <= herr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // SCI message generation, one per cycle with an enabled event pulse
    logic [`ESH_NUM_EV-1:0] ev_vec;
    logic [`ESH_NUM_EV-1:0] sci_hit;
    assign ev_vec[`ESH_BIT_OOA]   = out_of_aperture_i;
    assign ev_vec[`ESH_BIT_INV]   = invalid_gfx_access_i;
    assign ev_vec[`ESH_BIT_BADTT] = bad_translation_entry_i;
    assign ev_vec[`ESH_BIT_MBE]   = multibit_mem_error_i;
    assign ev_vec[`ESH_BIT_SBE]   = singlebit_mem_error_i;

    genvar gi;
    generate
        for (gi = 0; gi < `ESH_NUM_EV; gi = gi + 1) begin : g_sci
            // Cause bit gi maps to enable bit 4-gi
            assign sci_hit[gi] = ev_vec[gi] & sci_en_r[4-gi];
        end
    endgenerate

    wire        sci_nxt    = |sci_hit;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sci_msg_r   <= 1'b0;
            sci_cause_r <= 5'h00;
        end else begin
            sci_msg_r   <= sci_nxt;
            sci_cause_r <= sci_hit;
        end
    end

    assign sci_msg_o   = sci_msg_r;
    assign sci_cause_o = sci_cause_r;

    ////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by read, set wins
    wire [`ESH_NUM_IRQ-1:0] irq_ev  = {host_internal_error_signal_ev, host_bus_error_signal_ev, sci_hit};
    wire                    ist_rd  = rd & hit_ist;
    wire [`ESH_NUM_IRQ-1:0] irq_stat_nxt = irq_ev | (ist_rd ? 7'h00 : irq_stat_r);
    wire [`ESH_NUM_IRQ-1:0] irq_mask_nxt = (wr && hit_imk && wb_sel_i[0]) ?
        wb_dat_i[`ESH_NUM_IRQ-1:0] : irq_mask_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_r <= 7'h00;
            irq_mask_r <= 7'h00;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////
    // Read mux and bus answer
    wire [31:0] rd_mux =
        hit_sci  ? {16'h0000, sci_en_r}  :
        hit_scr  ? {16'h0000, scratch_r} :
        hit_herr ? {16'h0000, herr_r}    :
        hit_ist  ? {25'h0000000, irq_stat_r} :
        hit_imk  ? {25'h0000000, irq_mask_r} : 32'h00000000;

    wire esh_bus_st_t bus_st_nxt = req ? ESH_ACK : ESH_IDLE;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_st_r <= ESH_IDLE;
            rdat_r   <= 32'h00000000;
            err_r    <= 1'b0;
        end else begin
            bus_st_r <= bus_st_nxt;
            rdat_r   <= rd ? rd_mux : 32'h00000000;
            err_r    <= req & ~hit_any;
        end
    end

    always_comb begin
        case (bus_st_r)
            ESH_IDLE: begin
                wb_ack_o = 1'b0;
                wb_err_o = 1'b0;
            end
            ESH_ACK: begin
                wb_ack_o = ~err_r;
                wb_err_o = err_r;
            end
            default: begin
                wb_ack_o = 1'b0;
                wb_err_o = 1'b0;
            end
        endcase
    end

    assign wb_dat_o = rdat_r;

endmodule : esh_bank

// file: inc/esh_regs.svh
/*
 * Register offsets, field positions and reset values of the error SCI
 * enable, scratch storage and host error status bank.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef ESH_REGS_SVH
`define ESH_REGS_SVH

`define ESH_OFF_SCI_EN      8'hce
`define ESH_OFF_SCRATCH     8'hd0
`define ESH_OFF_HERR        8'he0
`define ESH_OFF_IRQ_STAT    8'hf0
`define ESH_OFF_IRQ_MASK    8'hf4

`define ESH_SCI_EN_RST      16'h0000
`define ESH_SCRATCH_RST     16'h0000
`define ESH_HERR_RST        16'h0000
`define ESH_SCI_EN_MASK     16'h001f

`define ESH_BIT_OOA         0
`define ESH_BIT_INV         1
`define ESH_BIT_BADTT       2
`define ESH_BIT_MBE         3
`define ESH_BIT_SBE         4
`define ESH_BIT_HOST_BUS_ERROR_SIGNAL        5
`define ESH_BIT_HOST_INTERNAL_ERROR_SIGNAL        6

`define ESH_HERR_HOST_BUS_ERROR_SIGNAL       15
`define ESH_HERR_HOST_INTERNAL_ERROR_SIGNAL       14

`define ESH_NUM_EV          5
`define ESH_NUM_IRQ         7

`endif

// file: inc/esh_pkg.sv
/*
 * Types shared by the error SCI enable and host status bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package esh_pkg;
    typedef logic [15:0] esh_word_t;
    typedef enum logic [0:0] {
        ESH_IDLE = 1'b0,
        ESH_ACK  = 1'b1
    } esh_bus_st_t;
endpackage : esh_pkg

// file: bench/esh_bank_asserts.sv
/* Port checker for the SCI enable bank.
   Assumes a bind onto esh_bank, one clock domain. */
`timescale 1ns/1ps
module esh_bank_asserts (
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic       wb_ack_o,
    input wire logic       out_of_aperture_i,
    input wire logic       invalid_gfx_access_i,
    input wire logic       bad_translation_entry_i,
    input wire logic       multibit_mem_error_i,
    input wire logic       singlebit_mem_error_i,
    input wire logic       sci_msg_o,
    input wire logic [4:0] sci_cause_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_cause_outside: assert property (sci_msg_o && sci_cause_o[0] |-> $past(out_of_aperture_i))
        else $error("outside cause without event");
    a_cause_invalid: assert property (sci_msg_o && sci_cause_o[1] |-> $past(invalid_gfx_access_i))
        else $error("invalid cause without event");
    a_cause_badtt: assert property (sci_msg_o && sci_cause_o[2] |-> $past(bad_translation_entry_i))
        else $error("entry cause without event");
    a_cause_multibit: assert property (sci_msg_o && sci_cause_o[3] |-> $past(multibit_mem_error_i))
        else $error("multibit cause without event");
    a_cause_single: assert property (sci_msg_o && sci_cause_o[4] |-> $past(singlebit_mem_error_i))
        else $error("single cause without event");
    a_msg_has_cause: assert property (sci_msg_o |-> sci_cause_o != 5'h00)
        else $error("message without cause");
    a_quiet_no_msg: assert property (!(out_of_aperture_i || invalid_gfx_access_i
        || bad_translation_entry_i || multibit_mem_error_i || singlebit_mem_error_i) |=> !sci_msg_o)
        else $error("message without event");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule : esh_bank_asserts
bind esh_bank esh_bank_asserts u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_ack_o(wb_ack_o),
    .out_of_aperture_i(out_of_aperture_i), .invalid_gfx_access_i(invalid_gfx_access_i),
    .bad_translation_entry_i(bad_translation_entry_i), .multibit_mem_error_i(multibit_mem_error_i),
    .singlebit_mem_error_i(singlebit_mem_error_i), .sci_msg_o(sci_msg_o), .sci_cause_o(sci_cause_o));

// file: bench/esh_hub_model.sv
/* Downstream hub model counting SCI messages.
   Assumes one-cycle message pulses on the bank clock. */
`timescale 1ns/1ps
module esh_hub_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       sci_msg_i,
    input  wire logic [4:0] sci_cause_i,
    output int              msg_cnt_o,
    output logic [4:0]      last_cause_o
);
    // One message counted per pulse
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            msg_cnt_o <= 0;
            last_cause_o <= 5'h00;
        end else if (sci_msg_i) begin
            msg_cnt_o <= msg_cnt_o + 1;
            last_cause_o <= sci_cause_i;
        end
    end
endmodule : esh_hub_model

// file: bench/esh_bank_tb_top.sv
/* Testbench for the SCI enable bank.
   Assumes the hub model and the bound checker. */
`timescale 1ns/1ps
module esh_bank_tb_top
    import esh_pkg::*;
;
    typedef struct packed { logic [7:0] a; esh_word_t d; esh_word_t x; } esh_row_t;
    logic        clk = 1'b0, rstn_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic        ack, err, irq, msg, got_err;
    logic [4:0]  ev = 5'h00, cause, last_cause;
    logic [1:0]  hn = 2'h3;
    int          errors = 0, checks = 0, cyc_cnt = 0, msg_cnt, base;
    esh_row_t    rows [4] = '{'{8'hd0, 16'ha5c3, 16'ha5c3}, '{8'hd0, 16'h5a3c, 16'h5a3c},
                              '{8'hce, 16'hffff, 16'h001f}, '{8'he0, 16'h3fff, 16'h0000}};
    always #5 clk = ~clk;
    esh_bank uut (.sys_clk_i(clk), .rstn_i(rstn_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .out_of_aperture_i(ev[0]), .invalid_gfx_access_i(ev[1]),
        .bad_translation_entry_i(ev[2]), .multibit_mem_error_i(ev[3]),
        .singlebit_mem_error_i(ev[4]), .host_bus_error_signal_n_i(hn[0]),
        .host_internal_error_signal_n_i(hn[1]), .sci_msg_o(msg), .sci_cause_o(cause), .irq_o(irq));
    esh_hub_model hub (.sys_clk_i(clk), .rstn_i(rstn_n), .sci_msg_i(msg), .sci_cause_i(cause),
        .msg_cnt_o(msg_cnt), .last_cause_o(last_cause));
    //////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input esh_word_t d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do @(posedge clk); while (!(ack || err));
        rdat = dat_o;
        got_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic pulse(input logic [4:0] e);
        ev <= e;
        @(posedge clk);
        ev <= 5'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    //////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rstn_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'he0, 16'h0000);
        chk(rdat, 32'h0);
        bus(1'b0, 8'h10, 16'h0000);
        chk({31'h0, got_err}, 32'h1);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 16'h0000);
            chk(rdat, {16'h0000, rows[i].x});
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'hce, 16'h0010 >> i);
            base = msg_cnt;
            pulse(5'h1f);
            chk(32'(msg_cnt - base), 32'h1);
            chk({27'h0, last_cause}, 32'h1 << i);
        end
        bus(1'b1, 8'hce, 16'h0000);
        base = msg_cnt;
        pulse(5'h1f);
        chk(32'(msg_cnt - base), 32'h0);
        bus(1'b0, 8'hf0, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, 8'hf4, 16'h0020 << j);
            hn <= 2'h3 ^ (2'h1 << j);
            repeat (5) @(posedge clk);
            hn <= 2'h3;
            chk({31'h0, irq}, 32'h1);
            bus(1'b0, 8'hf0, 16'h0000);
            chk(rdat, 32'h20 << j);
            chk({31'h0, irq}, 32'h0);
            bus(1'b1, 8'he0, 16'h0000);
            bus(1'b0, 8'he0, 16'h0000);
            chk(rdat, 32'h8000 >> j);
            bus(1'b1, 8'he0, 16'h8000 >> j);
            bus(1'b0, 8'he0, 16'h0000);
            chk(rdat, 32'h0);
        end
        tally_and_finish();
    end
endmodule : esh_bank_tb_top
